// ---- bench/rcs_supply_model.sv ----
// partner model: external clear pin with weak pull-up and the supply monitor
`timescale 1ns/10ps

module rcs_supply_model (
   // requests from the bench
   input  wire logic clear_low,
   input  wire logic brown_dip,
   // pins toward the sequencer
   output logic      master_clear_pin,
   output logic      brownout_low
);
   // ---------------------------------------------------------------------
   // pin and monitor behaviour
   // ---------------------------------------------------------------------
   // only the button pulls low; the sequencer never drives this pin, so the
   // pull-up is the idle level
   always_comb master_clear_pin = clear_low ? 1'b0 : 1'b1;
   // flag stays high for as long as the supply sits below the trip point
   always_comb brownout_low = brown_dip;
endmodule : rcs_supply_model

// ---- bench/tb.sv ----
// self-checking bench for the reset cause sequencer
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_errors++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module tb
   import rcs_pkg::*;
;
   // short counts keep the power-up delay at about sixteen cycles
   localparam int LFD = 4;
   localparam int PWT = 4;
   localparam int FLT = 3;
   logic        clk, resetn, sleep_instr, watchdog_clear_instr, wdt_timeout, irq_wake;
   logic        global_irq_enable, instr_retired, reg_wr, reg_rd, clear_low, brown_dip;
   logic [12:0] pc_current, pc_value;
   logic [1:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata;
   logic        core_reset, pc_load, vector_req, sleeping, master_clear_pin, brownout_low;
   int          n_errors = 0;
   int          num_checks = 0;
   int          c;

   rcs_supply_model rcs_supply_model_i (.clear_low(clear_low), .brown_dip(brown_dip),
      .master_clear_pin(master_clear_pin), .brownout_low(brownout_low));
   rcs_sequencer #(.LF_DIV(LFD), .DLY_TICKS(PWT), .FILT_CYCLES(FLT)) rcs_sequencer_i (
      .clk(clk), .resetn(resetn), .master_clear_pin(master_clear_pin),
      .brownout_low(brownout_low), .sleep_instr(sleep_instr),
      .watchdog_clear_instr(watchdog_clear_instr), .wdt_timeout(wdt_timeout),
      .irq_wake(irq_wake), .global_irq_enable(global_irq_enable),
      .instr_retired(instr_retired), .pc_current(pc_current), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .core_reset(core_reset), .pc_load(pc_load), .pc_value(pc_value),
      .vector_req(vector_req), .sleeping(sleeping));

   // ---------------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------------
   // register write, one strobe cycle
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr
   // register read; data only stand in the cycle after the strobe
   task automatic rd(input logic [1:0] a, input logic [7:0] ex, input string nm);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      `CHK(nm, ex, reg_rdata)
   endtask : rd
   // one-cycle core event: 0 watchdog, 1 sleep, 2 clear watchdog, 3 irq, else retire
   task automatic pulse(input int k);
      @(posedge clk);
      if (k == 0) wdt_timeout <= 1'b1;
      else if (k == 1) sleep_instr <= 1'b1;
      else if (k == 2) watchdog_clear_instr <= 1'b1;
      else if (k == 3) irq_wake <= 1'b1;
      else instr_retired <= 1'b1;
      @(posedge clk);
      {wdt_timeout, sleep_instr, watchdog_clear_instr, irq_wake, instr_retired} <= 5'h00;
      #1;
   endtask : pulse
   // bounded wait: 0 core_reset low, 1 vector_req high, 2 core_reset high
   task automatic wt(input int k, input int n, output int cnt);
      for (cnt = 0; cnt < n; cnt++)
      begin
         @(posedge clk);
         #1;
         if ((k == 0 && core_reset === 1'b0) || (k == 1 && vector_req === 1'b1) ||
             (k == 2 && core_reset === 1'b1)) break;
      end
      `CHK("wait", 1'b1, cnt < n)
   endtask : wt
   // core must stay out of reset for n cycles
   task automatic quiet(input int n);
      int bad;
      bad = 0;
      repeat (n)
      begin
         @(posedge clk);
         #1;
         if (core_reset !== 1'b0) bad++;
      end
      `CHK("quiet", 0, bad)
   endtask : quiet
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results

   // ---------------------------------------------------------------------
   // clock, watchdog and test sequence
   // ---------------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // run needs well under 2000 cycles; this cuts a hang
   initial
   begin
      #20000;
      n_errors++;
      results();
   end
   initial
   begin
      {resetn, sleep_instr, watchdog_clear_instr, wdt_timeout, irq_wake} = 5'h00;
      {instr_retired, reg_wr, reg_rd, clear_low, brown_dip} = 5'h00;
      global_irq_enable = 1'b1;
      pc_current = 13'h0000;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      wt(0, 200, c);
      // slow tick runs free, so the first delay tick may come up to one period early
      `CHK("por delay", 1'b1, c >= (PWT - 1) * LFD && c <= PWT * LFD + 2)
      `CHK("por load", 14'h2000, {pc_load, pc_value})
      rd(OFS_STATUS, 8'h18, "por status");
      rd(OFS_PWRC, 8'h00, "por flags");
      rd(OFS_CFG, 8'h05, "cfg reset");
      wr(OFS_PWRC, 8'hFF);
      wr(OFS_STATUS, 8'hE7);
      wr(OFS_CAUSE, 8'h07);
      rd(OFS_STATUS, 8'hFF, "status write");
      rd(OFS_PWRC, 8'h03, "flag pad");
      rd(OFS_CAUSE, CS_POR, "cause ro");
      $display("test power-on done");
      pulse(0);
      `CHK("wdt hold", 1'b1, core_reset)
      @(posedge clk);
      #1;
      `CHK("wdt load", 15'h2000, {core_reset, pc_load, pc_value})
      rd(OFS_STATUS, 8'h0F, "wdt status");
      rd(OFS_CAUSE, CS_WDT_RUN, "wdt cause");
      pulse(2);
      rd(OFS_STATUS, 8'h1F, "wdt clear");
      pulse(1);
      `CHK("asleep", 1'b1, sleeping)
      rd(OFS_STATUS, 8'h17, "sleep status");
      pc_current <= 13'h0123;
      pulse(0);
      `CHK("wdt wake", 16'h2124, {core_reset, sleeping, pc_load, pc_value})
      rd(OFS_STATUS, 8'h07, "wake status");
      rd(OFS_CAUSE, CS_WDT_WAKE, "wake cause");
      $display("test watchdog done");
      pulse(1);
      pc_current <= 13'h0200;
      pulse(3);
      `CHK("irq wake", 15'h2201, {core_reset, pc_load, pc_value})
      rd(OFS_STATUS, 8'h17, "irq status");
      rd(OFS_CAUSE, CS_IRQ_WAKE, "irq cause");
      pulse(4);
      // the vector request stands only in the cycle after the retire
      `CHK("irq vector", 1'b1, vector_req)
      pulse(1);
      global_irq_enable <= 1'b0;
      pulse(3);
      pulse(4);
      `CHK("no vector", 1'b0, vector_req)
      global_irq_enable <= 1'b1;
      $display("test interrupt wake done");
      wr(OFS_STATUS, 8'hA7);
      @(posedge clk);
      clear_low <= 1'b1;
      repeat (2) @(posedge clk);
      clear_low <= 1'b0;
      quiet(12);
      clear_low <= 1'b1;
      wt(2, 20, c);
      clear_low <= 1'b0;
      wt(0, 20, c);
      `CHK("no delay", 1'b1, c < 8)
      rd(OFS_STATUS, 8'h17, "clear status");
      rd(OFS_CAUSE, CS_PIN_RUN, "clear cause");
      wr(OFS_STATUS, 8'h27);
      pulse(1);
      clear_low <= 1'b1;
      wt(2, 20, c);
      clear_low <= 1'b0;
      wt(0, 20, c);
      rd(OFS_STATUS, 8'h17, "clr sleep status");
      rd(OFS_CAUSE, CS_PIN_SLP, "clr sleep cause");
      $display("test clear pin done");
      brown_dip <= 1'b1;
      wt(2, 10, c);
      repeat (4) @(posedge clk);
      brown_dip <= 1'b0;
      wt(0, 200, c);
      `CHK("brown delay", 1'b1, c >= (PWT - 1) * LFD && c <= PWT * LFD + 2)
      rd(OFS_STATUS, 8'h1F, "brown status");
      rd(OFS_PWRC, 8'h02, "brown flags");
      rd(OFS_CAUSE, CS_BRN, "brown cause");
      // pin disabled; delay kept enabled while brown-out detection is on
      wr(OFS_CFG, 8'h04);
      @(posedge clk);
      clear_low <= 1'b1;
      quiet(20);
      clear_low <= 1'b0;
      // detection off: a dip must not hold the core
      wr(OFS_CFG, 8'h02);
      brown_dip <= 1'b1;
      quiet(10);
      brown_dip <= 1'b0;
      // detection on, delay disabled: release comes straight after the dip
      wr(OFS_CFG, 8'h06);
      brown_dip <= 1'b1;
      wt(2, 10, c);
      brown_dip <= 1'b0;
      wt(0, 20, c);
      `CHK("no brown delay", 1'b1, c < 6)
      $display("test brown-out and pin enable done");
      results();
   end
endmodule : tb

// ---- hdl/rcs_pkg.sv ----
// package: constants, codes and state layout of the reset cause sequencer
package rcs_pkg;

   // --------------------------------------------------------------------
   // clocks and timing
   // --------------------------------------------------------------------
   localparam int CLK_HZ          = 200_000_000;           // core clock rate
   localparam int LF_OSC_HZ       = 31_000;                // low-frequency oscillator
   localparam int DLY_MS          = 64;                    // power-up delay, nominal
   localparam int LF_DIV_DFLT     = CLK_HZ / LF_OSC_HZ;    // core cycles per lf tick
   localparam int DLY_TICKS_DFLT  = (DLY_MS * LF_OSC_HZ) / 1000;
   localparam int FILT_DFLT       = 16;                    // clear-pin filter, cycles
   localparam int LF_W            = 16;
   localparam int DLY_W           = 12;
   localparam int FLT_W           = 8;

   // --------------------------------------------------------------------
   // register map (byte offsets on the plain register port)
   // --------------------------------------------------------------------
   localparam logic [1:0] OFS_STATUS = 2'h0;
   localparam logic [1:0] OFS_PWRC   = 2'h1;
   localparam logic [1:0] OFS_CAUSE  = 2'h2;
   localparam logic [1:0] OFS_CFG    = 2'h3;

   // field positions
   localparam int ST_BANK_LSB = 5;   // bank select bits 7:5
   localparam int ST_TMO_BIT  = 4;   // timeout_flag
   localparam int ST_PWD_BIT  = 3;   // powerdown_flag
   localparam int PC_POR_BIT  = 1;   // poweron_flag
   localparam int PC_BRN_BIT  = 0;   // brownout_flag
   localparam int CF_MCE_BIT  = 0;   // ext_clear_pin_enable
   localparam int CF_PDD_BIT  = 1;   // powerup_delay_disable
   localparam int CF_BRE_BIT  = 2;   // brownout detection enable

   // reset values of the configuration bits
   localparam logic CFG_MCE_RST = 1'b1;
   localparam logic CFG_PDD_RST = 1'b0;
   localparam logic CFG_BRE_RST = 1'b1;

   // program counter values
   localparam logic [12:0] PC_RESET_VEC = 13'h0000;
   localparam logic [12:0] PC_IRQ_VEC   = 13'h0004;
   localparam logic [12:0] PC_STEP      = 13'h0001;

   // reset / wake cause codes
   localparam logic [2:0] CS_POR       = 3'h0;
   localparam logic [2:0] CS_BRN       = 3'h1;
   localparam logic [2:0] CS_WDT_RUN   = 3'h2;
   localparam logic [2:0] CS_WDT_WAKE  = 3'h3;
   localparam logic [2:0] CS_PIN_RUN   = 3'h4;
   localparam logic [2:0] CS_PIN_SLP   = 3'h5;
   localparam logic [2:0] CS_IRQ_WAKE  = 3'h6;

   // sequencer states, one-hot
   typedef enum logic [3:0] {
      RCS_HOLD  = 4'h1,
      RCS_DELAY = 4'h2,
      RCS_RUN   = 4'h4,
      RCS_SLEEP = 4'h8
   } rcs_state_t;

   // the whole state of the sequencer
   typedef struct packed {
      rcs_state_t       st;
      logic             pin_s1;
      logic             pin_s2;
      logic             brn_s1;
      logic             brn_s2;
      logic [FLT_W-1:0] flt_cnt;
      logic             pin_hold;
      logic [LF_W-1:0]  lf_cnt;
      logic [DLY_W-1:0] dly_cnt;
      logic             armed;
      logic [2:0]       bank;
      logic             timeout_flag;
      logic             powerdown_flag;
      logic [2:0]       arith;
      logic             poweron_flag;
      logic             brownout_flag;
      logic [2:0]       cause;
      logic             cfg_mce;
      logic             cfg_pdd;
      logic             cfg_bre;
      logic             vec_pend;
      logic             vec_req;
      logic             pc_load;
      logic [12:0]      pc_val;
      logic             core_rst;
      logic [7:0]       rdata;
   } rcs_regs_t;

endpackage : rcs_pkg

// ---- hdl/rcs_sequencer.sv ----
// reset generation, power-up delay and reset cause recording
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps

module rcs_sequencer
   import rcs_pkg::*;
#(
   parameter int LF_DIV      = LF_DIV_DFLT,
   parameter int DLY_TICKS   = DLY_TICKS_DFLT,
   parameter int FILT_CYCLES = FILT_DFLT
)(
   // clock and power-on reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // pins and supply monitor, asynchronous
   input  wire logic        master_clear_pin,
   input  wire logic        brownout_low,
   // core events, same clock
   input  wire logic        sleep_instr,
   input  wire logic        watchdog_clear_instr,
   input  wire logic        wdt_timeout,
   input  wire logic        irq_wake,
   input  wire logic        global_irq_enable,
   input  wire logic        instr_retired,
   input  wire logic [12:0] pc_current,
   // register port
   input  wire logic [1:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // core control
   output logic             core_reset,
   output logic             pc_load,
   output logic      [12:0] pc_value,
   output logic             vector_req,
   output logic             sleeping
);

   // --------------------------------------------------------------------
   // state and reset image
   // --------------------------------------------------------------------
   // power-on image: hold, power-up delay armed; unknown bits chosen as zero
   localparam rcs_regs_t RST_VAL = '{
      st: RCS_HOLD, pin_s1: 1'b1, pin_s2: 1'b1, brn_s1: 1'b0, brn_s2: 1'b0,
      flt_cnt: '0, pin_hold: 1'b0, lf_cnt: '0, dly_cnt: '0, armed: 1'b1,
      bank: 3'h0, timeout_flag: 1'b1, powerdown_flag: 1'b1, arith: 3'h0,
      poweron_flag: 1'b0, brownout_flag: 1'b0, cause: CS_POR,
      cfg_mce: CFG_MCE_RST, cfg_pdd: CFG_PDD_RST, cfg_bre: CFG_BRE_RST,
      vec_pend: 1'b0, vec_req: 1'b0, pc_load: 1'b0, pc_val: PC_RESET_VEC,
      core_rst: 1'b1, rdata: 8'h00};

   rcs_regs_t s_q;
   rcs_regs_t s_d;

   // status byte as software sees it
   function automatic logic [7:0] status_byte(input rcs_regs_t s);
      status_byte = {s.bank, s.timeout_flag, s.powerdown_flag, s.arith};
   endfunction : status_byte

   // power control byte; upper bits are unimplemented and read zero
   function automatic logic [7:0] pwrc_byte(input rcs_regs_t s);
      pwrc_byte = {6'h00, s.poweron_flag, s.brownout_flag};
   endfunction : pwrc_byte

   logic pin_low;
   logic brn_hold;
   logic lf_tick;

   // qualified hold sources
   assign pin_low  = ~s_q.pin_s2 & s_q.cfg_mce;
   assign brn_hold = s_q.brn_s2 & s_q.cfg_bre;
   assign lf_tick  = (s_q.lf_cnt == LF_W'(LF_DIV - 1));

   // --------------------------------------------------------------------
   // next-state logic
   // --------------------------------------------------------------------
   always_comb
   begin
      s_d         = s_q;
      s_d.pc_load = 1'b0;
      s_d.vec_req = 1'b0;
      s_d.rdata   = 8'h00;
      // pins pass two flops before anything reads them
      s_d.pin_s1  = master_clear_pin;
      s_d.pin_s2  = s_q.pin_s1;
      s_d.brn_s1  = brownout_low;
      s_d.brn_s2  = s_q.brn_s1;

      // glitch filter: a low level must stand for the whole window
      if (!pin_low)
      begin
         s_d.flt_cnt  = '0;
         s_d.pin_hold = 1'b0;
      end
      else if (s_q.flt_cnt != FLT_W'(FILT_CYCLES))
         s_d.flt_cnt = s_q.flt_cnt + FLT_W'(1);
      else
         s_d.pin_hold = 1'b1;

      // low-frequency tick derived from the core clock
      s_d.lf_cnt = lf_tick ? '0 : s_q.lf_cnt + LF_W'(1);

      // software writes; flags the hardware sets are overridden below
      if (reg_wr && !s_q.core_rst)
      begin
         case (reg_addr)
            OFS_STATUS:
            begin
               // timeout and powerdown flags are read-only
               s_d.bank  = reg_wdata[7:ST_BANK_LSB];
               s_d.arith = reg_wdata[2:0];
            end
            OFS_PWRC:
            begin
               s_d.poweron_flag  = reg_wdata[PC_POR_BIT];
               s_d.brownout_flag = reg_wdata[PC_BRN_BIT];
            end
            OFS_CFG:
            begin
               s_d.cfg_mce = reg_wdata[CF_MCE_BIT];
               s_d.cfg_pdd = reg_wdata[CF_PDD_BIT];
               s_d.cfg_bre = reg_wdata[CF_BRE_BIT];
            end
            default: ;
         endcase
      end

      // reads answer in the next cycle; unmapped cannot occur with 2 bits
      if (reg_rd)
      begin
         case (reg_addr)
            OFS_STATUS: s_d.rdata = status_byte(s_q);
            OFS_PWRC:   s_d.rdata = pwrc_byte(s_q);
            OFS_CAUSE:  s_d.rdata = {5'h00, s_q.cause};
            OFS_CFG:    s_d.rdata = {5'h00, s_q.cfg_bre, s_q.cfg_pdd, s_q.cfg_mce};
            default:    s_d.rdata = 8'h00;
         endcase
      end

      // sequencer; brown-out first, then the clear pin, then the rest
      if (brn_hold)
      begin
         s_d.st             = RCS_HOLD;
         s_d.brownout_flag  = 1'b0;
         s_d.timeout_flag   = 1'b1;
         s_d.powerdown_flag = 1'b1;
         s_d.bank           = 3'h0;
         s_d.cause          = CS_BRN;
         s_d.armed          = 1'b1;
         s_d.vec_pend       = 1'b0;
      end
      else if (s_q.pin_hold)
      begin
         s_d.bank     = 3'h0;
         s_d.vec_pend = 1'b0;
         s_d.st       = RCS_HOLD;
         if (s_q.st == RCS_SLEEP)
         begin
            s_d.timeout_flag   = 1'b1;
            s_d.powerdown_flag = 1'b0;
            s_d.cause          = CS_PIN_SLP;
         end
         else if (s_q.st == RCS_RUN)
            s_d.cause = CS_PIN_RUN;
      end
      else
      begin
         case (s_q.st)
            RCS_HOLD:
            begin
               // every hold source gone; run the delay only after power-on/brown-out
               if (s_q.armed && !s_q.cfg_pdd)
               begin
                  s_d.st      = RCS_DELAY;
                  s_d.dly_cnt = '0;
               end
               else
               begin
                  s_d.st      = RCS_RUN;
                  s_d.armed   = 1'b0;
                  s_d.pc_load = 1'b1;
                  s_d.pc_val  = PC_RESET_VEC;
               end
            end
            RCS_DELAY:
            begin
               if (lf_tick)
               begin
                  if (s_q.dly_cnt == DLY_W'(DLY_TICKS - 1))
                  begin
                     s_d.st      = RCS_RUN;
                     s_d.armed   = 1'b0;
                     s_d.pc_load = 1'b1;
                     s_d.pc_val  = PC_RESET_VEC;
                  end
                  else
                     s_d.dly_cnt = s_q.dly_cnt + DLY_W'(1);
               end
            end
            RCS_RUN:
            begin
               if (wdt_timeout)
               begin
                  // watchdog reset: one held cycle, no power-up delay
                  s_d.st             = RCS_HOLD;
                  s_d.timeout_flag   = 1'b0;
                  s_d.powerdown_flag = 1'b1;
                  s_d.bank           = 3'h0;
                  s_d.cause          = CS_WDT_RUN;
                  s_d.vec_pend       = 1'b0;
               end
               else if (sleep_instr)
               begin
                  s_d.st             = RCS_SLEEP;
                  s_d.timeout_flag   = 1'b1;
                  s_d.powerdown_flag = 1'b0;
               end
               else if (watchdog_clear_instr)
               begin
                  s_d.timeout_flag   = 1'b1;
                  s_d.powerdown_flag = 1'b1;
               end
               // vector fires after the instruction at pc plus one retires
               if (s_q.vec_pend && instr_retired && !wdt_timeout)
               begin
                  s_d.vec_pend = 1'b0;
                  s_d.vec_req  = 1'b1;
               end
            end
            RCS_SLEEP:
            begin
               if (wdt_timeout)
               begin
                  // a wake, not a reset: registers keep their values
                  s_d.st             = RCS_RUN;
                  s_d.timeout_flag   = 1'b0;
                  s_d.powerdown_flag = 1'b0;
                  s_d.cause          = CS_WDT_WAKE;
                  s_d.pc_load        = 1'b1;
                  s_d.pc_val         = pc_current + PC_STEP;
               end
               else if (irq_wake)
               begin
                  s_d.st             = RCS_RUN;
                  s_d.timeout_flag   = 1'b1;
                  s_d.powerdown_flag = 1'b0;
                  s_d.cause          = CS_IRQ_WAKE;
                  s_d.pc_load        = 1'b1;
                  s_d.pc_val         = pc_current + PC_STEP;
                  s_d.vec_pend       = global_irq_enable;
               end
            end
            default: s_d.st = RCS_HOLD;
         endcase
      end

      // core reset is high whenever the next state is hold or delay, clocked out
      s_d.core_rst = (s_d.st == RCS_HOLD) || (s_d.st == RCS_DELAY);
   end

   // --------------------------------------------------------------------
   // state register
   // --------------------------------------------------------------------
   // resetn is the power-on detector; it forces the power-on image
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         s_q <= RST_VAL;
      else
         s_q <= s_d;
   end

   // outputs straight from the state register; no pin driver exists for the clear pin
   assign reg_rdata  = s_q.rdata;
   assign core_reset = s_q.core_rst;
   assign pc_load    = s_q.pc_load;
   assign pc_value   = s_q.pc_val;
   assign vector_req = s_q.vec_req;
   assign sleeping   = s_q.st[3];                              // one-hot sleep bit

   // --------------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   logic free_run;
   assign free_run = !brn_hold && !s_q.pin_hold;

   reset_pc_a: assert property (pc_load && (s_q.cause != CS_WDT_WAKE)
      && (s_q.cause != CS_IRQ_WAKE) |-> pc_value == PC_RESET_VEC)
      else $error("reset did not restart at address zero");
   wdt_wake_a: assert property (sleeping && wdt_timeout && free_run |=>
      pc_load && !core_reset && pc_value == $past(pc_current) + PC_STEP
      && !s_q.timeout_flag && !s_q.powerdown_flag)
      else $error("watchdog wake from sleep wrong");
   wdt_reset_a: assert property ((s_q.st == RCS_RUN) && wdt_timeout && free_run
      |=> core_reset && !s_q.timeout_flag && s_q.powerdown_flag && s_q.bank == 3'h0
      ##1 !core_reset && pc_load)
      else $error("watchdog reset sequence wrong");
   brownout_a: assert property (brn_hold |=> core_reset && !s_q.brownout_flag
      && s_q.timeout_flag && s_q.powerdown_flag && s_q.armed)
      else $error("brown-out did not record or hold");
   pin_off_a: assert property (!s_q.cfg_mce [*2] |-> !s_q.pin_hold)
      else $error("disabled clear pin still acted");
   filter_len_a: assert property ($rose(s_q.pin_hold) |->
      s_q.flt_cnt == FLT_W'(FILT_CYCLES) && $past(pin_low))
      else $error("clear pin filter released early");
   sleep_flag_a: assert property ((s_q.st == RCS_RUN) && sleep_instr
      && !wdt_timeout && free_run |=> sleeping && s_q.timeout_flag && !s_q.powerdown_flag)
      else $error("sleep did not set flags");
   delay_hold_a: assert property ((s_q.st == RCS_DELAY) |-> core_reset)
      else $error("core ran during power-up delay");
   por_flags_a: assert property (core_reset && s_q.cause == CS_POR
      |-> s_q.timeout_flag && s_q.powerdown_flag && !s_q.poweron_flag)
      else $error("power-on flags inconsistent");
   irq_vec_a: assert property (vector_req |-> $past(instr_retired)
      && !core_reset)
      else $error("vector request without retired instruction");

   por_done_c:  cover property ((s_q.st == RCS_DELAY) ##1 (s_q.st == RCS_RUN));
   wdt_wake_c:  cover property (sleeping && wdt_timeout ##1 pc_load);
   irq_vec_c:   cover property (sleeping && irq_wake && global_irq_enable ##[1:20] vector_req);
   pin_slp_c:   cover property (sleeping && s_q.pin_hold ##1 core_reset);

endmodule : rcs_sequencer
